// ---- pce_apb_host.sv ----
// apb master model standing in for the processor core
`timescale 1ns/1ps
module pce_apb_host (
    input  wire logic        pclk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [5:0]       paddr,
    output logic [31:0]      pwdata
);
    initial
    begin
        psel    = 1'h0;
        penable = 1'h0;
        pwrite  = 1'h0;
        paddr   = 6'h00;
        pwdata  = 32'h00000000;
    end

    // one transfer at a time; the idle cycle after it keeps each signal single-driven per step
    task automatic xfer(input logic w, input logic [5:0] a, input logic [7:0] d,
                        output logic [31:0] q, output logic e);
        psel    <= 1'h1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'h1;
        do
            @(posedge pclk);
        while (pready !== 1'h1);
        q       = prdata;
        e       = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        // released data must not keep showing the last value
        pwdata  <= ~pwdata;
        @(posedge pclk);
    endtask
endmodule

// ---- pce_byte_step.sv ----
// folds one message byte into a crc of width W, most significant bit first
`timescale 1ns/1ps
module pce_byte_step #(
    parameter int W = 16
) (
    input  wire logic [W-1:0] crc_in,
    input  wire logic [W-1:0] poly,
    input  wire logic [7:0]   data,
    output logic      [W-1:0] crc_out
);

    always_comb
    begin
        logic [W-1:0] c;
        c = crc_in ^ {data, {(W-8){1'b0}}};
        for (int i = 0; i < 8; i++)
        begin
            if (c[W-1])
            begin
                c = {c[W-2:0], 1'b0} ^ poly;
            end
            else
            begin
                c = {c[W-2:0], 1'b0};
            end
        end
        crc_out = c;
    end

endmodule

// ---- pce_pkg.sv ----
// shared constants and types for the programmable crc engine
package pce_pkg;

    localparam int          ADDR_W      = 6;
    localparam int          DATA_W      = 32;
    localparam int          BYTE_W      = 8;
    localparam int          CRC_W       = 32;
    localparam int          IDX_W       = 4;

    // register indexes; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_DATA0 = 4'h0;
    localparam logic [IDX_W-1:0] IDX_DATA1 = 4'h1;
    localparam logic [IDX_W-1:0] IDX_DATA2 = 4'h2;
    localparam logic [IDX_W-1:0] IDX_DATA3 = 4'h3;
    localparam logic [IDX_W-1:0] IDX_POLY0 = 4'h4;
    localparam logic [IDX_W-1:0] IDX_POLY1 = 4'h5;
    localparam logic [IDX_W-1:0] IDX_POLY2 = 4'h6;
    localparam logic [IDX_W-1:0] IDX_POLY3 = 4'h7;
    localparam logic [IDX_W-1:0] IDX_CTRL  = 4'h8;
    localparam logic [1:0]       WORD_ALIGN = 2'h0;

    localparam logic [CRC_W-1:0] DATA_RST  = 32'hFFFFFFFF;
    localparam logic [CRC_W-1:0] POLY_RST  = 32'h00001021;

    // reversal select codes; the other two codes are reserved
    localparam logic [1:0]  REV_NONE    = 2'h0;
    localparam logic [1:0]  REV_IN_BYTE = 2'h1;

    localparam int          HALF_W      = 16;
    localparam logic [31:0] RD_ZERO     = 32'h00000000;

    typedef struct packed {
        logic [1:0] input_reverse_sel;
        logic [1:0] output_reverse_sel;
        logic       rsvd;
        logic       result_invert;
        logic       seed_load;
        logic       width_sel;
    } pce_ctrl_t;

    localparam pce_ctrl_t CTRL_RST = 8'h00;

endpackage

// ---- pce_top.sv ----
// apb slave wrapping the byte-serial programmable crc engine
//
// Contract
// - poly bits 31:16 used only in 32-bit mode
// - poly bits 15:0 used in both widths
// - poly bytes one..three hold bits 23:16,15:8,7:0
// - control 7:6 selects input byte mirroring
// - control 5:4 selects output byte mirroring
// - control bit 3 reads zero, ignores writes
// - control bit 2 complements checksum reads
// - control bit 1 makes data writes seed
// - control bit 0 selects 16 or 32 bits
// - each lowest data byte write folds in while control bit 1 is clear
// - checksum readable in data registers afterwards
// - input and output reversal act independently
// - mirroring keeps each byte in place
// - upper data writes ignored in data mode
// - data registers reset to all ones
// - polynomial resets to 0x1021, upper cleared
// - stop standby suspends then resumes computation
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
module pce_top (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [pce_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    input  wire logic                       stop_mode,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr
);

    pce_pkg::pce_ctrl_t                 ctrl_r;
    logic [pce_pkg::CRC_W-1:0]          crc_r;
    logic [pce_pkg::CRC_W-1:0]          poly_r;
    logic [31:0]                        prdata_r;

    logic [pce_pkg::IDX_W-1:0]          idx;
    logic                               addr_ok;
    logic                               setup;
    logic                               access;
    logic                               wr_take;
    logic                               is_data;
    logic                               byte_req;
    logic                               byte_take;
    logic [7:0]                         wbyte;
    logic [7:0]                         fold_byte;
    logic [15:0]                        crc16_nxt;
    logic [31:0]                        crc32_nxt;
    logic [pce_pkg::CRC_W-1:0]          view;
    logic [31:0]                        rd_val;
    logic [1:0]                         byte_sel;

    function automatic logic [7:0] mirror(input logic [7:0] b);
        logic [7:0] m;
        m = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            m[i] = b[7-i];
        end
        return m;
    endfunction

    // bus decode
    assign idx     = paddr[pce_pkg::ADDR_W-1:2];
    assign addr_ok = (paddr[1:0] == pce_pkg::WORD_ALIGN) && (idx <= pce_pkg::IDX_CTRL);
    assign setup   = psel && !penable;
    assign access  = psel && penable;
    assign is_data = (idx <= pce_pkg::IDX_DATA3);
    assign wbyte   = pwdata[7:0];

    // a message byte write while in data mode
    assign byte_req = access && pwrite && addr_ok && !ctrl_r.seed_load
                      && (idx == pce_pkg::IDX_DATA3);

    // stop standby holds the byte write in its access phase until run returns
    assign pready    = !(byte_req && stop_mode);
    assign pslverr   = access && !addr_ok;
    assign wr_take   = access && pwrite && pready && addr_ok;
    assign byte_take = byte_req && pready;
    assign prdata    = prdata_r;

    assign fold_byte = (ctrl_r.input_reverse_sel == pce_pkg::REV_IN_BYTE)
                       ? mirror(wbyte) : wbyte;

    // one step per width; the fold is combinational so it lands on the write edge
    pce_byte_step #(
        .W (pce_pkg::HALF_W)
    ) u_step16 (
        .crc_in  (crc_r[15:0]),
        .poly    (poly_r[15:0]),
        .data    (fold_byte),
        .crc_out (crc16_nxt)
    );

    pce_byte_step #(
        .W (pce_pkg::CRC_W)
    ) u_step32 (
        .crc_in  (crc_r),
        .poly    (poly_r),
        .data    (fold_byte),
        .crc_out (crc32_nxt)
    );

    // control register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= pce_pkg::CTRL_RST;
        end
        else if (wr_take && idx == pce_pkg::IDX_CTRL)
        begin
            ctrl_r      <= wbyte;
            ctrl_r.rsvd <= 1'b0;
        end
    end

    // polynomial bytes, byte zero is the top of the word
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            poly_r <= pce_pkg::POLY_RST;
        end
        else if (wr_take)
        begin
            case (idx)
                pce_pkg::IDX_POLY0: poly_r[31:24] <= wbyte;
                pce_pkg::IDX_POLY1: poly_r[23:16] <= wbyte;
                pce_pkg::IDX_POLY2: poly_r[15:8]  <= wbyte;
                pce_pkg::IDX_POLY3: poly_r[7:0]   <= wbyte;
                default:            poly_r        <= poly_r;
            endcase
        end
    end

    // seed, running checksum and result share one register
    assign byte_sel = 2'(pce_pkg::IDX_DATA3 - idx);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            crc_r <= pce_pkg::DATA_RST;
        end
        else if (wr_take && is_data && ctrl_r.seed_load)
        begin
            crc_r[byte_sel*8 +: 8] <= wbyte;
        end
        else if (byte_take)
        begin
            // upper half keeps its seed in 16-bit mode
            if (ctrl_r.width_sel)
            begin
                crc_r <= crc32_nxt;
            end
            else
            begin
                crc_r[15:0] <= crc16_nxt;
            end
        end
    end
    // writes to the upper data bytes in data mode fall through untouched

    // read view: complement, then per-byte mirror, bytes never reordered
    always_comb
    begin
        view = ctrl_r.result_invert ? ~crc_r : crc_r;
        if (ctrl_r.output_reverse_sel == pce_pkg::REV_IN_BYTE)
        begin
            for (int k = 0; k < 4; k++)
            begin
                view[k*8 +: 8] = mirror(view[k*8 +: 8]);
            end
        end
    end

    always_comb
    begin
        rd_val = pce_pkg::RD_ZERO;
        if (addr_ok)
        begin
            case (idx)
                pce_pkg::IDX_DATA0,
                pce_pkg::IDX_DATA1,
                pce_pkg::IDX_DATA2,
                pce_pkg::IDX_DATA3: rd_val[7:0] = view[byte_sel*8 +: 8];
                pce_pkg::IDX_POLY0: rd_val[7:0] = poly_r[31:24];
                pce_pkg::IDX_POLY1: rd_val[7:0] = poly_r[23:16];
                pce_pkg::IDX_POLY2: rd_val[7:0] = poly_r[15:8];
                pce_pkg::IDX_POLY3: rd_val[7:0] = poly_r[7:0];
                pce_pkg::IDX_CTRL:  rd_val[7:0] = ctrl_r;
                default:            rd_val      = pce_pkg::RD_ZERO;
            endcase
        end
    end

    // read data is captured in the setup cycle; the previous write has
    // already landed, so a read straight after a byte write is current
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r <= pce_pkg::RD_ZERO;
        end
        else if (setup && !pwrite)
        begin
            prdata_r <= rd_val;
        end
    end

    sequence s_byte_taken;
        byte_take && ctrl_r.input_reverse_sel == pce_pkg::REV_NONE;
    endsequence

    sequence s_read_data(logic [pce_pkg::IDX_W-1:0] i);
        setup && !pwrite && addr_ok && idx == i;
    endsequence

    sequence s_stalled;
        byte_req && stop_mode;
    endsequence

    a_ctrl_rsvd_zero: assert property (@(posedge pclk) disable iff (!presetn)
        s_read_data(pce_pkg::IDX_CTRL) |=> !prdata_r[3])
        else $error("reserved control bit read as one");

    a_seed_byte_load: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_take && ctrl_r.seed_load && idx == pce_pkg::IDX_DATA1)
        |=> crc_r[23:16] == $past(pwdata[7:0]))
        else $error("seed byte not loaded");

    a_upper_ignored: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_take && !ctrl_r.seed_load && idx < pce_pkg::IDX_DATA3) |=> $stable(crc_r))
        else $error("upper data write changed checksum");

    a_fold_sixteen: assert property (@(posedge pclk) disable iff (!presetn)
        (s_byte_taken and !ctrl_r.width_sel)
        |=> crc_r[15:0] == $past(crc16_nxt) && crc_r[31:16] == $past(crc_r[31:16]))
        else $error("16-bit fold wrong");

    a_fold_wide: assert property (@(posedge pclk) disable iff (!presetn)
        (byte_take && ctrl_r.width_sel) |=> crc_r == $past(crc32_nxt))
        else $error("32-bit fold wrong");

    a_stop_stall: assert property (@(posedge pclk) disable iff (!presetn)
        s_stalled |-> !pready ##1 $stable(crc_r))
        else $error("byte folded during stop standby");

    a_in_mirror: assert property (@(posedge pclk) disable iff (!presetn)
        (byte_req && ctrl_r.input_reverse_sel == pce_pkg::REV_IN_BYTE)
        |-> fold_byte[0] == wbyte[7] && fold_byte[7] == wbyte[0])
        else $error("input byte not mirrored");

    a_invert_read: assert property (@(posedge pclk) disable iff (!presetn)
        (s_read_data(pce_pkg::IDX_DATA3) and ctrl_r.result_invert
         && ctrl_r.output_reverse_sel == pce_pkg::REV_NONE)
        |=> prdata_r[7:0] == ~crc_r[7:0])
        else $error("complemented read wrong");

    a_out_mirror: assert property (@(posedge pclk) disable iff (!presetn)
        (s_read_data(pce_pkg::IDX_DATA0) and !ctrl_r.result_invert
         && ctrl_r.output_reverse_sel == pce_pkg::REV_IN_BYTE)
        |=> prdata_r[0] == crc_r[31] && prdata_r[7] == crc_r[24])
        else $error("output byte mirror wrong");

    a_poly_upper: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_take && idx == pce_pkg::IDX_POLY1) |=> poly_r[23:16] == $past(pwdata[7:0]))
        else $error("polynomial byte one not stored");

    // storage, read-back and stall checks
    a_ctrl_store: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_take && idx == pce_pkg::IDX_CTRL)
        |=> ctrl_r == {$past(pwdata[7:4]), 1'b0, $past(pwdata[2:0])})
        else $error("control write not stored");

    a_ctrl_read: assert property (@(posedge pclk) disable iff (!presetn)
        s_read_data(pce_pkg::IDX_CTRL) |=> prdata_r[7:0] == ctrl_r)
        else $error("control read mismatch");

    a_poly_top: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_take && idx == pce_pkg::IDX_POLY0) |=> poly_r[31:24] == $past(pwdata[7:0]))
        else $error("polynomial byte zero not stored");

    a_poly_mid: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_take && idx == pce_pkg::IDX_POLY2) |=> poly_r[15:8] == $past(pwdata[7:0]))
        else $error("polynomial byte two not stored");

    a_poly_low: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_take && idx == pce_pkg::IDX_POLY3) |=> poly_r[7:0] == $past(pwdata[7:0]))
        else $error("polynomial byte three not stored");

    a_poly_read: assert property (@(posedge pclk) disable iff (!presetn)
        s_read_data(pce_pkg::IDX_POLY2) |=> prdata_r[7:0] == poly_r[15:8])
        else $error("polynomial read mismatch");

    a_seed_top: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_take && ctrl_r.seed_load && idx == pce_pkg::IDX_DATA0)
        |=> crc_r[31:24] == $past(pwdata[7:0]))
        else $error("seed byte zero not loaded");

    a_seed_mid: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_take && ctrl_r.seed_load && idx == pce_pkg::IDX_DATA2)
        |=> crc_r[15:8] == $past(pwdata[7:0]))
        else $error("seed byte two not loaded");

    a_seed_low: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_take && ctrl_r.seed_load && idx == pce_pkg::IDX_DATA3)
        |=> crc_r[7:0] == $past(pwdata[7:0]))
        else $error("seed byte three not loaded");

    // seed writes and folds are the only ways the checksum moves
    a_crc_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !(byte_take || (wr_take && is_data && ctrl_r.seed_load)) |=> $stable(crc_r))
        else $error("checksum changed without fold or seed write");

    a_read_high_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite) |=> !(|prdata_r[31:8]))
        else $error("read data upper bits not zero");

    a_read_raw: assert property (@(posedge pclk) disable iff (!presetn)
        (s_read_data(pce_pkg::IDX_DATA2) and !ctrl_r.result_invert
         && ctrl_r.output_reverse_sel != pce_pkg::REV_IN_BYTE)
        |=> prdata_r[7:0] == crc_r[15:8])
        else $error("raw checksum read wrong");

    a_out_mirror_mid: assert property (@(posedge pclk) disable iff (!presetn)
        (s_read_data(pce_pkg::IDX_DATA1) and ctrl_r.result_invert
         && ctrl_r.output_reverse_sel == pce_pkg::REV_IN_BYTE)
        |=> prdata_r[0] == !crc_r[23] && prdata_r[7] == !crc_r[16])
        else $error("complemented mirrored read wrong");

    a_ready_other: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !byte_req) |-> pready)
        else $error("access stalled outside a byte write");

endmodule

// ---- tb.sv ----
// self-checking bench for the programmable crc engine
`timescale 1ns/1ps
module tb;
    logic        pclk;
    logic        presetn;
    logic        stop_mode;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [5:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] crc;
    logic [7:0]  ctl;
    int          fail_count = 0;
    int          n_compared = 0;

    pce_top pce_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .stop_mode(stop_mode),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    pce_apb_host pce_apb_host_i (.pclk(pclk), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata));

    initial
    begin
        pclk = 1'h0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] i, input logic [7:0] d);
        logic [31:0] q;
        logic        e;
        pce_apb_host_i.xfer(1'h1, {i, 2'h0}, d, q, e);
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] exp, input logic err);
        logic [31:0] q;
        logic        e;
        pce_apb_host_i.xfer(1'h0, a, 8'h00, q, e);
        chk(q, {24'h000000, exp});
        chk({31'h0, e}, {31'h0, err});
    endtask

    task automatic setc(input logic [7:0] v);
        ctl = v;
        wr(pce_pkg::IDX_CTRL, v);
    endtask

    function automatic logic [7:0] mir(input logic [7:0] b);
        for (int k = 0; k < 8; k++)
            mir[k] = b[7-k];
    endfunction

    // model of one byte fold, msb first, width and input mirror taken from ctl
    function automatic logic [31:0] fold(input logic [31:0] c, input logic [31:0] p,
                                         input logic [7:0] b);
        logic [7:0] m;
        m = (ctl[7:6] == pce_pkg::REV_IN_BYTE) ? mir(b) : b;
        if (ctl[0])
        begin
            c[31:24] ^= m;
            for (int j = 0; j < 8; j++)
                c = c[31] ? {c[30:0], 1'h0} ^ p : {c[30:0], 1'h0};
        end
        else
        begin
            c[15:8] ^= m;
            for (int j = 0; j < 8; j++)
                c[15:0] = c[15] ? {c[14:0], 1'h0} ^ p[15:0] : {c[14:0], 1'h0};
        end
        return c;
    endfunction

    task automatic chk_crc;
        logic [31:0] v;
        logic [7:0]  b;
        v = ctl[2] ? ~crc : crc;
        for (int k = 0; k < 4; k++)
        begin
            b = v[31-8*k -: 8];
            rd({k[3:0], 2'h0}, (ctl[5:4] == pce_pkg::REV_IN_BYTE) ? mir(b) : b, 1'h0);
        end
    endtask

    task automatic t_reset;
        logic [7:0] rv [9] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h10, 8'h21, 8'h00};
        for (int k = 0; k < 9; k++)
            rd({k[3:0], 2'h0}, rv[k], 1'h0);
        rd(6'h24, 8'h00, 1'h1);
        rd(6'h01, 8'h00, 1'h1);
    endtask

    task automatic t_ctrl;
        setc(8'hFF);
        rd(6'h20, 8'hF7, 1'h0);
        setc(8'hAA);
        rd(6'h20, 8'hA2, 1'h0);
    endtask

    task automatic t_crc32;
        logic [7:0] p [4] = '{8'h04, 8'hC1, 8'h1D, 8'hB7};
        logic [7:0] s [4] = '{8'h12, 8'h34, 8'h56, 8'h78};
        setc(8'h01);
        for (int k = 0; k < 4; k++)
            wr(pce_pkg::IDX_POLY0 + k[3:0], p[k]);
        setc(8'h03);
        for (int k = 0; k < 4; k++)
            wr(pce_pkg::IDX_DATA0 + k[3:0], s[k]);
        crc = 32'h12345678;
        chk_crc();
        setc(8'h55);
        wr(pce_pkg::IDX_DATA0, 8'h99);
        for (int k = 0; k < 16; k++)
        begin
            wr(pce_pkg::IDX_DATA3, k[7:0] * 8'h1D + 8'h03);
            crc = fold(crc, 32'h04C11DB7, k[7:0] * 8'h1D + 8'h03);
        end
        chk_crc();
    endtask

    task automatic t_crc16;
        setc(8'h00);
        wr(pce_pkg::IDX_POLY2, 8'h10);
        wr(pce_pkg::IDX_POLY3, 8'h21);
        setc(8'h02);
        wr(pce_pkg::IDX_DATA2, 8'hFF);
        wr(pce_pkg::IDX_DATA3, 8'hFF);
        crc[15:0] = 16'hFFFF;
        // reserved reversal codes must act as no reversal
        setc(8'hA0);
        for (int k = 0; k < 256; k++)
        begin
            wr(pce_pkg::IDX_DATA3, 8'h41);
            crc = fold(crc, 32'h04C11021, 8'h41);
        end
        rd(6'h08, 8'hEA, 1'h0);
        rd(6'h0C, 8'h0B, 1'h0);
        chk_crc();
    endtask

    task automatic t_stop;
        setc(8'h00);
        stop_mode <= 1'h1;
        fork
            wr(pce_pkg::IDX_DATA3, 8'h5A);
            begin
                repeat (6) @(posedge pclk);
                #1 chk({31'h0, pready}, 32'h00000000);
                @(posedge pclk);
                stop_mode <= 1'h0;
            end
        join
        crc = fold(crc, 32'h04C11021, 8'h5A);
        chk_crc();
        setc(8'h04);
        chk_crc();
        setc(8'h10);
        chk_crc();
    endtask

    task automatic print_verdict;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial
    begin
        presetn   = 1'h0;
        stop_mode = 1'h0;
        ctl       = 8'h00;
        crc       = 32'h00000000;
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        t_reset();
        t_ctrl();
        t_crc32();
        t_crc16();
        t_stop();
        print_verdict();
    end

    // the whole run needs about 1000 cycles
    initial
    begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        print_verdict();
    end
endmodule
